// File: verilog/ccr_pkg.sv
// Constants, types and field helpers shared by the chroma coordinate readback block
package ccr_pkg;

  // ==========================================================================
  // Widths
  localparam int CMD_W    = 16;
  localparam int BYTE_W   = 8;
  localparam int COORD_W  = 10;
  localparam int WORD_W   = 2 * COORD_W;
  localparam int BANKS    = 3;
  localparam int BANK_W   = 2;

  // ==========================================================================
  // Command codes, short form; the 16-bit serial form appends SPI_TAIL
  localparam logic [7:0] OP_GREEN_X   = 8'h78;
  localparam logic [7:0] OP_GREEN_Y   = 8'h79;
  localparam logic [7:0] OP_BLUE_ALT  = 8'h7A;
  localparam logic [7:0] OP_BLUE_X    = 8'h7B;
  localparam logic [7:0] OP_BLUE_Y    = 8'h7C;
  localparam logic [7:0] SPI_TAIL     = 8'h00;

  // ==========================================================================
  // Coordinate store banks; each word holds x in the upper half, y in the lower
  localparam logic [1:0] BANK_GREEN = 2'h0;
  localparam logic [1:0] BANK_BLUE  = 2'h1;
  localparam logic [1:0] BANK_ALT   = 2'h2;

  localparam int X_HI = 19;
  localparam int X_UP = 12;
  localparam int X_LO = 10;
  localparam int Y_HI = 9;
  localparam int Y_UP = 2;
  localparam int Y_LO = 0;

  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  localparam logic [19:0] COORD_ZERO = 20'h00000;

  // ==========================================================================
  // Command kinds and responder states
  typedef enum logic [5:0] {
    CCR_K_NONE  = 6'h01,
    CCR_K_GX    = 6'h02,
    CCR_K_GY    = 6'h04,
    CCR_K_LOW   = 6'h08,
    CCR_K_BX    = 6'h10,
    CCR_K_BY    = 6'h20
  } ccr_kind_t;

  typedef enum logic [4:0] {
    CCR_S_IDLE   = 5'h01,
    CCR_S_FETCH  = 5'h02,
    CCR_S_FETCH2 = 5'h04,
    CCR_S_DUMMY  = 5'h08,
    CCR_S_SEND   = 5'h10
  } ccr_state_t;

  // ==========================================================================
  // Field helpers
  function automatic logic [7:0] ccr_x_upper(input logic [19:0] w);
    ccr_x_upper = w[X_HI:X_UP];
  endfunction

  function automatic logic [7:0] ccr_y_upper(input logic [19:0] w);
    ccr_y_upper = w[Y_HI:Y_UP];
  endfunction

  function automatic logic [3:0] ccr_low_pair(input logic [19:0] w);
    ccr_low_pair = {w[X_UP-1:X_LO], w[Y_UP-1:Y_LO]};
  endfunction

endpackage

// File: verilog/ccr_coord_mem.sv
// Coordinate store: three x/y words, written by the panel loader, registered read
`timescale 1ns/1ps
module ccr_coord_mem
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_we,
  input  wire logic [1:0]  i_waddr,
  input  wire logic [19:0] i_wdata,
  input  wire logic [1:0]  i_raddr,
  output logic      [19:0] o_rdata
);

  // ==========================================================================
  // Storage
  // Rows are not reset: their content is panel specific, not a fixed default
  logic [19:0] row      [ccr_pkg::BANKS];
  logic [19:0] next_row [ccr_pkg::BANKS];
  logic [19:0] next_rdata;

  genvar g;
  generate
    for (g = 0; g < ccr_pkg::BANKS; g++)
    begin : g_row
      always_comb
      begin
        next_row[g] = row[g];
        if (i_we && (i_waddr == ccr_pkg::BANK_W'(g)))
          next_row[g] = i_wdata;
      end

      always_ff @(posedge i_clk)
      begin
        row[g] <= next_row[g];
      end
    end
  endgenerate

  // ==========================================================================
  // Read port; a write in the same cycle is seen on the next read
  always_comb
  begin
    next_rdata = ccr_pkg::COORD_ZERO;
    if (i_raddr < ccr_pkg::BANK_W'(ccr_pkg::BANKS))
      next_rdata = row[i_raddr];
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
      o_rdata <= ccr_pkg::COORD_ZERO;
    else
      o_rdata <= next_rdata;
  end

endmodule

// File: verilog/ccr_readback.sv
// Chroma coordinate readback responder for green, blue and alternate colour
`timescale 1ns/1ps
module ccr_readback
(
  input  wire logic        i_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_cmd_valid,
  input  wire logic [15:0] i_cmd,
  input  wire logic        i_cmd_spi,
  input  wire logic        i_nv_we,
  input  wire logic [1:0]  i_nv_addr,
  input  wire logic [19:0] i_nv_wdata,
  output logic             o_busy,
  output logic             o_rsp_valid,
  output logic             o_rsp_dummy,
  output logic      [15:0] o_rsp_data
);

  // ==========================================================================
  // Command decode
  function automatic ccr_pkg::ccr_kind_t ccr_decode(input logic [15:0] cmd, input logic spi);
    logic [7:0] op;
    logic       form_ok;
    op      = spi ? cmd[15:8] : cmd[7:0];
    form_ok = spi ? (cmd[7:0] == ccr_pkg::SPI_TAIL) : 1'b1;
    ccr_decode = ccr_pkg::CCR_K_NONE;
    if (form_ok)
    begin
      case (op)
        ccr_pkg::OP_GREEN_X:  ccr_decode = ccr_pkg::CCR_K_GX;
        ccr_pkg::OP_GREEN_Y:  ccr_decode = ccr_pkg::CCR_K_GY;
        ccr_pkg::OP_BLUE_ALT: ccr_decode = ccr_pkg::CCR_K_LOW;
        ccr_pkg::OP_BLUE_X:   ccr_decode = ccr_pkg::CCR_K_BX;
        ccr_pkg::OP_BLUE_Y:   ccr_decode = ccr_pkg::CCR_K_BY;
        default:              ccr_decode = ccr_pkg::CCR_K_NONE;
      endcase
    end
  endfunction

  function automatic logic [1:0] ccr_first_bank(input ccr_pkg::ccr_kind_t k);
    case (k)
      ccr_pkg::CCR_K_GX,
      ccr_pkg::CCR_K_GY: ccr_first_bank = ccr_pkg::BANK_GREEN;
      default:           ccr_first_bank = ccr_pkg::BANK_BLUE;
    endcase
  endfunction

  // ==========================================================================
  // State
  ccr_pkg::ccr_state_t state;
  ccr_pkg::ccr_state_t next_state;
  ccr_pkg::ccr_kind_t  kind;
  ccr_pkg::ccr_kind_t  next_kind;
  ccr_pkg::ccr_kind_t  in_kind;
  logic                spi;
  logic                next_spi;
  logic [19:0]         word_a;
  logic [19:0]         next_word_a;
  logic [7:0]          hold;
  logic [7:0]          next_hold;
  logic [7:0]          fetched;
  logic                next_busy;
  logic                next_rsp_valid;
  logic                next_rsp_dummy;
  logic [15:0]         next_rsp_data;
  logic [1:0]          raddr;
  logic [19:0]         rdata;
  logic                accept;

  // No mode gating
  // Nothing here looks at display or sleep mode, so every state answers
  assign in_kind = ccr_decode(i_cmd, i_cmd_spi);
  assign accept  = i_cmd_valid && (state == ccr_pkg::CCR_S_IDLE) && (in_kind != ccr_pkg::CCR_K_NONE);

  // Read-only path
  // The store is written only by the loader port, never by a read
  ccr_coord_mem u_mem
  (
    .i_clk   (i_clk),
    .i_rstn  (i_rstn),
    .i_we    (i_nv_we),
    .i_waddr (i_nv_addr),
    .i_wdata (i_nv_wdata),
    .i_raddr (raddr),
    .o_rdata (rdata)
  );

  // ==========================================================================
  // Byte selection from the word just read
  always_comb
  begin
    fetched = ccr_pkg::BYTE_ZERO;
    case (kind)
      ccr_pkg::CCR_K_GX:  fetched = ccr_pkg::ccr_x_upper(rdata);
      ccr_pkg::CCR_K_GY:  fetched = ccr_pkg::ccr_y_upper(rdata);
      ccr_pkg::CCR_K_BX:  fetched = ccr_pkg::ccr_x_upper(rdata);
      ccr_pkg::CCR_K_BY:  fetched = ccr_pkg::ccr_y_upper(rdata);
      ccr_pkg::CCR_K_LOW: fetched = {ccr_pkg::ccr_low_pair(word_a), ccr_pkg::ccr_low_pair(rdata)};
      default:            fetched = ccr_pkg::BYTE_ZERO;
    endcase
  end

  // ==========================================================================
  // Responder sequence
  always_comb
  begin
    next_state     = state;
    next_kind      = kind;
    next_spi       = spi;
    next_word_a    = word_a;
    next_hold      = hold;
    next_rsp_valid = 1'b0;
    next_rsp_dummy = 1'b0;
    next_rsp_data  = ccr_pkg::WORD_ZERO;
    raddr          = ccr_pkg::BANK_GREEN;
    case (state)
      ccr_pkg::CCR_S_IDLE:
      begin
        if (accept)
        begin
          next_kind  = in_kind;
          next_spi   = i_cmd_spi;
          raddr      = ccr_first_bank(in_kind);
          next_state = ccr_pkg::CCR_S_FETCH;
        end
      end
      ccr_pkg::CCR_S_FETCH:
      begin
        if (kind == ccr_pkg::CCR_K_LOW)
        begin
          // Blue word kept while the alternate colour word is read
          next_word_a = rdata;
          raddr       = ccr_pkg::BANK_ALT;
          next_state  = ccr_pkg::CCR_S_FETCH2;
        end
        else
        begin
          next_hold = fetched;
          if (spi)
          begin
            next_rsp_valid = 1'b1;
            next_rsp_dummy = 1'b1;
            next_state     = ccr_pkg::CCR_S_DUMMY;
          end
          else
          begin
            next_rsp_valid = 1'b1;
            next_rsp_data  = {ccr_pkg::BYTE_ZERO, fetched};
            next_state     = ccr_pkg::CCR_S_SEND;
          end
        end
      end
      ccr_pkg::CCR_S_FETCH2:
      begin
        next_hold = fetched;
        if (spi)
        begin
          next_rsp_valid = 1'b1;
          next_rsp_dummy = 1'b1;
          next_state     = ccr_pkg::CCR_S_DUMMY;
        end
        else
        begin
          next_rsp_valid = 1'b1;
          next_rsp_data  = {ccr_pkg::BYTE_ZERO, fetched};
          next_state     = ccr_pkg::CCR_S_SEND;
        end
      end
      ccr_pkg::CCR_S_DUMMY:
      begin
        // Upper byte zero
        // Upper byte is don't-care to the host; zero keeps it deterministic
        next_rsp_valid = 1'b1;
        next_rsp_data  = {ccr_pkg::BYTE_ZERO, hold};
        next_state     = ccr_pkg::CCR_S_SEND;
      end
      ccr_pkg::CCR_S_SEND:
      begin
        next_state = ccr_pkg::CCR_S_IDLE;
      end
      default:
      begin
        next_state = ccr_pkg::CCR_S_IDLE;
      end
    endcase
    next_busy = (next_state != ccr_pkg::CCR_S_IDLE);
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_rstn)
    begin
      state       <= ccr_pkg::CCR_S_IDLE;
      kind        <= ccr_pkg::CCR_K_NONE;
      spi         <= 1'b0;
      word_a      <= ccr_pkg::COORD_ZERO;
      hold        <= ccr_pkg::BYTE_ZERO;
      o_busy      <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_dummy <= 1'b0;
      o_rsp_data  <= ccr_pkg::WORD_ZERO;
    end
    else
    begin
      state       <= next_state;
      kind        <= next_kind;
      spi         <= next_spi;
      word_a      <= next_word_a;
      hold        <= next_hold;
      o_busy      <= next_busy;
      o_rsp_valid <= next_rsp_valid;
      o_rsp_dummy <= next_rsp_dummy;
      o_rsp_data  <= next_rsp_data;
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rstn);

  // Shadow copy of the store, used only by the checks below
  logic [19:0] shadow      [ccr_pkg::BANKS];
  logic [19:0] next_shadow [ccr_pkg::BANKS];
  genvar s;
  generate
    for (s = 0; s < ccr_pkg::BANKS; s++)
    begin : g_shadow
      always_comb
      begin
        next_shadow[s] = shadow[s];
        if (i_nv_we && (i_nv_addr == ccr_pkg::BANK_W'(s)))
          next_shadow[s] = i_nv_wdata;
      end
      always_ff @(posedge i_clk)
      begin
        shadow[s] <= next_shadow[s];
      end
    end
  endgenerate

  logic quiet;
  assign quiet = !i_nv_we;

  AST_GREEN_X: assert property (
    (accept && in_kind == ccr_pkg::CCR_K_GX && !i_cmd_spi) ##0 quiet[*2]
    |=> o_rsp_valid && o_rsp_data[7:0] == ccr_pkg::ccr_x_upper(shadow[ccr_pkg::BANK_GREEN]))
    else $error("green x byte wrong");

  AST_GREEN_Y: assert property (
    (accept && in_kind == ccr_pkg::CCR_K_GY && !i_cmd_spi) ##0 quiet[*2]
    |=> o_rsp_valid && o_rsp_data[7:0] == ccr_pkg::ccr_y_upper(shadow[ccr_pkg::BANK_GREEN]))
    else $error("green y byte wrong");

  AST_LOW_BITS: assert property (
    (accept && in_kind == ccr_pkg::CCR_K_LOW && !i_cmd_spi) ##0 quiet[*3]
    |=> o_rsp_valid && o_rsp_data[7:0] == {ccr_pkg::ccr_low_pair(shadow[ccr_pkg::BANK_BLUE]),
                                          ccr_pkg::ccr_low_pair(shadow[ccr_pkg::BANK_ALT])})
    else $error("low bits byte wrong");

  AST_BLUE_X: assert property (
    (accept && in_kind == ccr_pkg::CCR_K_BX && i_cmd_spi) ##0 quiet[*3]
    |=> o_rsp_valid && !o_rsp_dummy && o_rsp_data[7:0] == ccr_pkg::ccr_x_upper(shadow[ccr_pkg::BANK_BLUE]))
    else $error("blue x byte wrong");

  AST_BLUE_Y: assert property (
    (accept && in_kind == ccr_pkg::CCR_K_BY && !i_cmd_spi) ##0 quiet[*2]
    |=> o_rsp_valid && o_rsp_data[7:0] == ccr_pkg::ccr_y_upper(shadow[ccr_pkg::BANK_BLUE]))
    else $error("blue y byte wrong");

  AST_NO_DUMMY: assert property (
    accept && !i_cmd_spi |-> ##1 !o_rsp_valid ##1 (o_rsp_valid || kind == ccr_pkg::CCR_K_LOW)
    ##0 !o_rsp_dummy [*3])
    else $error("dummy sent on short link");

  AST_SPI_DUMMY: assert property (
    o_rsp_valid && o_rsp_dummy |=> o_rsp_valid && !o_rsp_dummy ##1 !o_rsp_valid)
    else $error("serial dummy not followed by data");

  AST_ANSWERED: assert property (
    accept |-> ##[2:4] (o_rsp_valid && !o_rsp_dummy))
    else $error("read not answered");

  AST_UPPER_ZERO: assert property (
    o_rsp_valid |-> o_rsp_data[15:8] == ccr_pkg::BYTE_ZERO && o_busy)
    else $error("upper byte not zero or answer outside busy");

endmodule

// File: verification/ccr_host_model.sv
// Display host model: issues read commands and collects answer beats
`timescale 1ns/1ps
module ccr_host_model
(
  input  wire logic        i_clk,
  input  wire logic        i_busy,
  input  wire logic        i_rsp_valid,
  input  wire logic        i_rsp_dummy,
  input  wire logic [15:0] i_rsp_data,
  output logic             o_cmd_valid,
  output logic      [15:0] o_cmd,
  output logic             o_cmd_spi
);
  // Last cycle of the most recent read in which busy was seen high, -1 if never
  int busy_last;

  initial
  begin
    o_cmd_valid = 1'b0;
    o_cmd       = 16'h0000;
    o_cmd_spi   = 1'b0;
  end

  // ==========================================================================
  // Read transaction
  task automatic read_cmd(input logic [15:0] cmd, input logic spi, input int hold,
                          output logic [15:0] data, output int data_cyc, output int dum_cyc,
                          output int beats);
    int n;
    data     = 16'h0000;
    data_cyc = -1;
    dum_cyc  = -1;
    beats    = 0;
    busy_last = -1;
    @(posedge i_clk);
    #1;
    o_cmd_valid = 1'b1;
    o_cmd       = cmd;
    o_cmd_spi   = spi;
    for (n = 1; n <= 12; n++)
    begin
      @(posedge i_clk);
      #1;
      // Released command lines never keep the last value
      if (n == hold)
      begin
        o_cmd_valid = 1'b0;
        o_cmd       = ~cmd;
        o_cmd_spi   = ~spi;
      end
      // word taken as found, no reset value assumed
      if (i_busy === 1'b1)
        busy_last = n;
      if (i_rsp_valid === 1'b1)
      begin
        beats++;
        if (i_rsp_dummy === 1'b1)
          dum_cyc = n;
        else
        begin
          data     = i_rsp_data;
          data_cyc = n;
        end
      end
    end
  endtask
endmodule

// File: verification/ccr_readback_tb.sv
// Self-checking testbench for the chroma coordinate readback responder
`timescale 1ns/1ps
module ccr_readback_tb;
  logic        i_clk;
  logic        i_rstn;
  logic        i_nv_we;
  logic [1:0]  i_nv_addr;
  logic [19:0] i_nv_wdata;
  logic        cmd_valid;
  logic [15:0] cmd;
  logic        cmd_spi;
  logic        o_busy;
  logic        o_rsp_valid;
  logic        o_rsp_dummy;
  logic [15:0] o_rsp_data;
  logic [9:0]  cx [3];
  logic [9:0]  cy [3];
  int          fails;
  int          tests_run;

  ccr_readback u_dut (.i_clk(i_clk), .i_rstn(i_rstn), .i_cmd_valid(cmd_valid), .i_cmd(cmd),
    .i_cmd_spi(cmd_spi), .i_nv_we(i_nv_we), .i_nv_addr(i_nv_addr), .i_nv_wdata(i_nv_wdata),
    .o_busy(o_busy), .o_rsp_valid(o_rsp_valid), .o_rsp_dummy(o_rsp_dummy), .o_rsp_data(o_rsp_data));

  ccr_host_model u_host (.i_clk(i_clk), .i_busy(o_busy), .i_rsp_valid(o_rsp_valid),
    .i_rsp_dummy(o_rsp_dummy), .i_rsp_data(o_rsp_data), .o_cmd_valid(cmd_valid), .o_cmd(cmd),
    .o_cmd_spi(cmd_spi));

  always #2.5 i_clk = ~i_clk;

  // ==========================================================================
  // Compare and helper tasks
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("[ERR] %0t data got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chkint(input int got, input int exp);
    tests_run++;
    if (got != exp)
    begin
      fails++;
      $display("[ERR] %0t count got %0d expected %0d", $time, got, exp);
    end
  endtask

  task automatic load(input logic [1:0] a, input logic [9:0] x, input logic [9:0] y);
    @(posedge i_clk);
    #1;
    i_nv_we    = 1'b1;
    i_nv_addr  = a;
    i_nv_wdata = {x, y};
    @(posedge i_clk);
    #1;
    i_nv_we    = 1'b0;
    i_nv_wdata = ~{x, y};
    if (a != 2'h3)
    begin
      cx[a] = x;
      cy[a] = y;
    end
  endtask

  function automatic logic [7:0] expect_byte(input int k);
    case (k)
      0: expect_byte = cx[0][9:2];
      1: expect_byte = cy[0][9:2];
      2: expect_byte = {cx[1][1:0], cy[1][1:0], cx[2][1:0], cy[2][1:0]};
      3: expect_byte = cx[1][9:2];
      default: expect_byte = cy[1][9:2];
    endcase
  endfunction

  // ==========================================================================
  // Scenarios
  task automatic t_reads(input logic spi);
    logic [7:0]  ops [5];
    logic [15:0] d;
    int          dc;
    int          mc;
    int          b;
    int          lat;
    ops = '{ccr_pkg::OP_GREEN_X, ccr_pkg::OP_GREEN_Y, ccr_pkg::OP_BLUE_ALT,
            ccr_pkg::OP_BLUE_X, ccr_pkg::OP_BLUE_Y};
    for (int k = 0; k < 5; k++)
    begin
      lat = (k == 2) ? 3 : 2;
      u_host.read_cmd(spi ? {ops[k], 8'h00} : {8'hA5, ops[k]}, spi, 1, d, dc, mc, b);
      chk16(d, {8'h00, expect_byte(k)});
      chkint(dc, spi ? lat + 1 : lat);
      chkint(mc, spi ? lat : -1);
      chkint(b, spi ? 2 : 1);
      chkint(u_host.busy_last, spi ? lat + 1 : lat);
    end
  endtask

  task automatic t_refused();
    logic [15:0] d;
    int          dc;
    int          mc;
    int          b;
    u_host.read_cmd(16'h007D, 1'b0, 1, d, dc, mc, b);
    chkint(b, 0);
    chkint(u_host.busy_last, -1);
    u_host.read_cmd(16'h7801, 1'b1, 1, d, dc, mc, b);
    chkint(b, 0);
    // Strobe held while busy only; held past busy it is a fresh read
    u_host.read_cmd(16'h0079, 1'b0, 3, d, dc, mc, b);
    chkint(b, 1);
    chk16(d, {8'h00, cy[0][9:2]});
  endtask

  task automatic t_mid_reset();
    logic [15:0] d;
    int          dc;
    int          mc;
    int          b;
    fork
      u_host.read_cmd(16'h7A00, 1'b1, 1, d, dc, mc, b);
      begin
        repeat (3) @(posedge i_clk);
        #1;
        i_rstn = 1'b0;
        @(posedge i_clk);
        #1;
        i_rstn = 1'b1;
      end
    join
    chkint(b, 0);
    chk16({15'h0000, o_busy}, 16'h0000);
    u_host.read_cmd(16'h007B, 1'b0, 1, d, dc, mc, b);
    chk16(d, {8'h00, cx[1][9:2]});
  endtask

  // ==========================================================================
  // Verdict
  task automatic complete_run();
    $display("Mismatches %0d of %0d comparisons", fails, tests_run);
    if (fails == 0 && tests_run > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial
  begin
    #100000;
    fails++;
    complete_run();
  end

  initial
  begin
    i_clk      = 1'b0;
    i_rstn     = 1'b0;
    i_nv_we    = 1'b0;
    i_nv_addr  = 2'h0;
    i_nv_wdata = 20'h00000;
    fails      = 0;
    tests_run  = 0;
    repeat (3) @(posedge i_clk);
    #1;
    i_rstn = 1'b1;
    chk16(o_rsp_data, 16'h0000);
    load(2'h0, 10'h2D6, 10'h139);
    load(2'h1, 10'h3FF, 10'h000);
    load(2'h2, 10'h1E6, 10'h3A5);
    load(2'h3, 10'h000, 10'h3FF);
    // no mode inputs, so every read is taken in any state
    t_reads(1'b0);
    t_reads(1'b1);
    t_refused();
    // Inverted contents catch a store that never updates
    load(2'h0, 10'h129, 10'h2C6);
    load(2'h1, 10'h000, 10'h3FF);
    load(2'h2, 10'h219, 10'h05A);
    t_reads(1'b1);
    t_reads(1'b0);
    t_mid_reset();
    complete_run();
  end
endmodule
